// File: common/icr_pkg.sv
// Constants for the interface capability register block.
// Assumes every user refers to these names with the package prefix.
package icr_pkg;

    // Register width and field positions.
    localparam int CAP_W = 32;
    localparam int VENDOR_BIT = 31;
    localparam int REV_HI = 30;
    localparam int REV_LO = 28;
    localparam int RSVD_HI = 27;
    localparam int RSVD_LO = 11;
    localparam int SIZE_HI = 10;
    localparam int SIZE_LO = 9;
    localparam int FIXED_BIT = 8;
    localparam int CMDRDY_BIT = 7;
    localparam int FALL_BIT = 6;
    localparam int RISE_BIT = 5;
    localparam int LOW_BIT = 4;
    localparam int HIGH_BIT = 3;
    localparam int OWNSW_BIT = 2;
    localparam int SETTLED_BIT = 1;
    localparam int RESP_BIT = 0;

    // Interface revision codes.
    localparam logic [2:0] REV_LEGACY = 3'h0;
    localparam logic [2:0] REV_1P3 = 3'h2;
    localparam logic [2:0] REV_CURRENT = 3'h3;

    // Maximum transfer size codes.
    localparam logic [1:0] SIZE_LEGACY = 2'h0;
    localparam logic [1:0] SIZE_8 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;
    localparam logic [1:0] SIZE_64 = 2'h3;

    // Transfer lengths in bytes.
    localparam int LEN_W = 7;
    localparam logic [LEN_W-1:0] LEN_NONE = 7'h00;
    localparam logic [LEN_W-1:0] LEN_LEGACY = 7'h04;
    localparam logic [LEN_W-1:0] LEN_8 = 7'h08;
    localparam logic [LEN_W-1:0] LEN_32 = 7'h20;
    localparam logic [LEN_W-1:0] LEN_64 = 7'h40;

    // Interface kinds for which the register holds meaning.
    localparam logic [3:0] KIND_FIFO = 4'h0;
    localparam logic [3:0] KIND_FIFO_ALT = 4'hf;

    // Value of the mandatory capability bits.
    localparam logic MANDATORY_ONE = 1'b1;
    localparam logic [RSVD_HI-RSVD_LO:0] RSVD_ZERO = '0;

endpackage

// File: rtl/icr_reset_sync.sv
// Reset release synchroniser for the capability block.
// Assumes an active-low asynchronous reset from outside the clock domain.
`timescale 1ns/1ps
module icr_reset_sync
(
    input wire logic ref_clk,
    input wire logic nrst,
    output logic rstSync_n
);

    logic stage1_n;

    // Assert at once, release only after two clean edges.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_n <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            stage1_n <= 1'b1;
            rstSync_n <= stage1_n;
        end
    end

endmodule

// File: rtl/icr_cap_reg.sv
// Read-only interface capability register and data port size gate.
// Assumes register strobes and the interface kind come from logic
// on ref_clk, so none of them is synchronised here.
//
// What this block does
// - Report interface revision in three-bit field.
// - Reserved bits 27 to 11 read zero.
// - Encode maximum transfer size in two bits.
// - Larger size implies all smaller sizes work.
// - Bit 8 set when allowance is fixed.
// - Bit 7 shows command-ready interrupt support.
// - Bits 6, 5, 3 show optional triggers.
// - Low-level trigger always supported, bit 4.
// - Owner-switch interrupt always supported, bit 2.
// - Bit 1 shows status-settled interrupt support.
// - Response-ready interrupt always supported, bit 0.
// - Bit 31 reserved, vendor value, no meaning.
// - Valid only for interface kind 0000, 1111.
// - Legacy only: extended data port aborts.
// - Otherwise extended port accepts up to maximum.
`timescale 1ns/1ps
module icr_cap_reg
#(
    parameter logic [2:0] REVISION_CODE = icr_pkg::REV_CURRENT,
    parameter logic [1:0] SIZE_CODE = icr_pkg::SIZE_LEGACY,
    parameter logic FIXED_ALLOWANCE = 1'b0,
    parameter logic CMD_READY_IRQ = 1'b0,
    parameter logic FALLING_TRIG = 1'b0,
    parameter logic RISING_TRIG = 1'b0,
    parameter logic HIGH_TRIG = 1'b0,
    parameter logic SETTLED_IRQ = 1'b0,
    // Arbitrary value; the bit carries no meaning.
    parameter logic VENDOR_RESERVED = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] interfaceKind,
    input wire logic capSel,
    input wire logic capRead,
    input wire logic capWrite,
    input wire logic dataReq,
    input wire logic dataToExtended,
    input wire logic [icr_pkg::LEN_W-1:0] dataLen,
    output logic [icr_pkg::CAP_W-1:0] capRdata,
    output logic capAck,
    output logic capValid,
    output logic dataAccept,
    output logic dataAbort
);

    logic rstSync_n;
    logic [icr_pkg::CAP_W-1:0] capWord;
    logic kindOk;
    logic [icr_pkg::LEN_W-1:0] maxLen;
    logic lenOk;
    logic [icr_pkg::CAP_W-1:0] next_capRdata;
    logic next_capAck;
    logic next_capValid;
    logic next_dataAccept;
    logic next_dataAbort;

    icr_reset_sync u_rst
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rstSync_n(rstSync_n)
    );

    // Fixed capability word; every bit is set by parameters or constants.
    always_comb
    begin
        capWord = '0;
        capWord[icr_pkg::VENDOR_BIT] = VENDOR_RESERVED;
        capWord[icr_pkg::REV_HI:icr_pkg::REV_LO] = REVISION_CODE;
        capWord[icr_pkg::RSVD_HI:icr_pkg::RSVD_LO] = icr_pkg::RSVD_ZERO;
        capWord[icr_pkg::SIZE_HI:icr_pkg::SIZE_LO] = SIZE_CODE;
        capWord[icr_pkg::FIXED_BIT] = FIXED_ALLOWANCE;
        capWord[icr_pkg::CMDRDY_BIT] = CMD_READY_IRQ;
        capWord[icr_pkg::FALL_BIT] = FALLING_TRIG;
        capWord[icr_pkg::RISE_BIT] = RISING_TRIG;
        capWord[icr_pkg::HIGH_BIT] = HIGH_TRIG;
        capWord[icr_pkg::LOW_BIT] = icr_pkg::MANDATORY_ONE;
        capWord[icr_pkg::OWNSW_BIT] = icr_pkg::MANDATORY_ONE;
        capWord[icr_pkg::SETTLED_BIT] = SETTLED_IRQ;
        capWord[icr_pkg::RESP_BIT] = icr_pkg::MANDATORY_ONE;
    end

    assign kindOk = (interfaceKind == icr_pkg::KIND_FIFO) ||
                    (interfaceKind == icr_pkg::KIND_FIFO_ALT);

    // Largest accepted length for the advertised size code.
    always_comb
    begin
        if (SIZE_CODE == icr_pkg::SIZE_64)
        begin
            maxLen = icr_pkg::LEN_64;
        end
        else if (SIZE_CODE == icr_pkg::SIZE_32)
        begin
            maxLen = icr_pkg::LEN_32;
        end
        else if (SIZE_CODE == icr_pkg::SIZE_8)
        begin
            maxLen = icr_pkg::LEN_8;
        end
        else
        begin
            maxLen = icr_pkg::LEN_LEGACY;
        end
    end

    assign lenOk = (dataLen != icr_pkg::LEN_NONE) && (dataLen <= maxLen);

    // Next values for the read answer and the data port verdict.
    // A write is acknowledged like a read so the bus never hangs, but
    // the read data holds its last value.
    always_comb
    begin
        next_capRdata = capRdata;
        next_capAck = 1'b0;
        next_capValid = kindOk;
        next_dataAccept = 1'b0;
        next_dataAbort = 1'b0;
        if (capSel && capRead)
        begin
            next_capAck = 1'b1;
            // Invalid interface kinds read as all zeros.
            next_capRdata = kindOk ? capWord : '0;
        end
        else if (capSel && capWrite)
        begin
            next_capAck = 1'b1;
        end
        if (dataReq)
        begin
            if (dataToExtended && (SIZE_CODE == icr_pkg::SIZE_LEGACY))
            begin
                next_dataAbort = 1'b1;
            end
            else if (lenOk)
            begin
                next_dataAccept = 1'b1;
            end
            else
            begin
                next_dataAbort = 1'b1;
            end
        end
    end

    // Registered outputs; all clear during reset.
    always_ff @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            capRdata <= '0;
            capAck <= 1'b0;
            capValid <= 1'b0;
            dataAccept <= 1'b0;
            dataAbort <= 1'b0;
        end
        else
        begin
            capRdata <= next_capRdata;
            capAck <= next_capAck;
            capValid <= next_capValid;
            dataAccept <= next_dataAccept;
            dataAbort <= next_dataAbort;
        end
    end

    // Checks on the answer one cycle after each request.
    AST_REV_FIELD:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capRead && kindOk |=>
        capAck && capRdata[icr_pkg::REV_HI:icr_pkg::REV_LO] == REVISION_CODE)
    else $error("Revision field wrong after read.");

    AST_RSVD_ZERO:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capAck |-> capRdata[icr_pkg::RSVD_HI:icr_pkg::RSVD_LO] == '0)
    else $error("Reserved bits not zero.");

    AST_SIZE_FIELD:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capRead && kindOk |=>
        capRdata[icr_pkg::SIZE_HI:icr_pkg::SIZE_LO] == SIZE_CODE)
    else $error("Size field wrong after read.");

    AST_SMALLER_OK:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        dataReq && !dataToExtended && dataLen != icr_pkg::LEN_NONE &&
        dataLen <= icr_pkg::LEN_LEGACY |=> dataAccept && !dataAbort)
    else $error("Legacy length refused.");

    // A write acks with the old read data, so only reads are judged here.
    AST_LOW_TRIG:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capRead && kindOk |=> capRdata[icr_pkg::LOW_BIT])
    else $error("Low level trigger bit not set.");

    AST_OWNER_SWITCH:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capRead && kindOk |=> capRdata[icr_pkg::OWNSW_BIT])
    else $error("Owner switch bit not set.");

    AST_RESP_READY:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capRead ##1 capValid |-> capRdata[icr_pkg::RESP_BIT])
    else $error("Response ready bit not set.");

    AST_INVALID_ZERO:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capRead && !kindOk |=> !capValid && capRdata == '0)
    else $error("Invalid kind read not zero.");

    AST_EXT_ABORT:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        dataReq && dataToExtended && SIZE_CODE == icr_pkg::SIZE_LEGACY
        |=> dataAbort && !dataAccept)
    else $error("Extended port not aborted.");

    AST_EXT_ACCEPT:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        dataReq && SIZE_CODE != icr_pkg::SIZE_LEGACY &&
        dataLen != icr_pkg::LEN_NONE &&
        dataLen <= ((SIZE_CODE == icr_pkg::SIZE_64) ? icr_pkg::LEN_64 :
        (SIZE_CODE == icr_pkg::SIZE_32) ? icr_pkg::LEN_32 : icr_pkg::LEN_8)
        |=> dataAccept && !dataAbort)
    else $error("Length within maximum refused.");

    AST_WRITE_STABLE:
    assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        capSel && capWrite && !capRead |=> capAck && $stable(capRdata))
    else $error("Write altered read data.");

endmodule

// File: tb/icr_host_model.sv
// Host side model: issues capability register cycles and data requests.
// Assumes the device answers exactly one clock after each request edge.
`timescale 1ns/1ps
module icr_host_model
(
    input wire logic ref_clk,
    output logic [3:0] interfaceKind,
    output logic capSel,
    output logic capRead,
    output logic capWrite,
    output logic dataReq,
    output logic dataToExtended,
    output logic [icr_pkg::LEN_W-1:0] dataLen,
    input wire logic [icr_pkg::CAP_W-1:0] capRdata,
    input wire logic capAck,
    input wire logic dataAccept,
    input wire logic dataAbort
);
    // Idle values; the length bus is never left showing a stale value.
    initial
    begin
        interfaceKind = icr_pkg::KIND_FIFO;
        {capSel, capRead, capWrite, dataReq, dataToExtended} = '0;
        dataLen = 7'h55;
    end

    task automatic setKind(input logic [3:0] k);
        @(posedge ref_clk);
        #1;
        interfaceKind = k;
    endtask

    // One register cycle; the answer is looked at in the cycle it stands.
    task automatic regCycle(input logic wr, output logic [31:0] word,
        output logic ack);
        @(posedge ref_clk);
        #1;
        capSel = 1'b1;
        capRead = !wr;
        capWrite = wr;
        @(posedge ref_clk);
        #1;
        {capSel, capRead, capWrite} = '0;
        word = capRdata;
        ack = capAck;
    endtask

    // One data port request; released lines show the inverse value.
    task automatic dataCycle(input logic ext, input logic [6:0] len,
        output logic acc, output logic abt);
        @(posedge ref_clk);
        #1;
        dataReq = 1'b1;
        dataToExtended = ext;
        dataLen = len;
        @(posedge ref_clk);
        #1;
        dataReq = 1'b0;
        dataToExtended = !ext;
        dataLen = ~len;
        acc = dataAccept;
        abt = dataAbort;
    endtask
endmodule

// File: tb/tb_top.sv
// Testbench for the capability register, with a wide and a legacy copy.
// Assumes the host model drives every input but ref_clk and nrst shortly after each edge.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] interfaceKind;
    logic capSel, capRead, capWrite, dataReq, dataToExtended;
    logic [6:0] dataLen;
    logic [31:0] capRdata, capRdata2;
    logic capAck, capValid, dataAccept, dataAbort, dataAccept2, dataAbort2;
    logic capAck2, capValid2;
    int failures = 0;
    int compares = 0;
    // Wide copy: rev 011, size 10, bits 8,7,6,4,3,2,0 set.
    localparam logic [31:0] WIDE = 32'h3000_05dd;
    // Legacy copy: rev 010, size 00, bits 31,5,4,2,1,0 set.
    localparam logic [31:0] LEGACY = 32'ha000_0037;

    always #10 ref_clk = ~ref_clk;

    icr_cap_reg #(.SIZE_CODE(icr_pkg::SIZE_32), .FIXED_ALLOWANCE(1'b1),
        .CMD_READY_IRQ(1'b1), .FALLING_TRIG(1'b1), .HIGH_TRIG(1'b1))
    icr_cap_reg_i (.ref_clk(ref_clk), .nrst(nrst),
        .interfaceKind(interfaceKind), .capSel(capSel), .capRead(capRead),
        .capWrite(capWrite), .dataReq(dataReq),
        .dataToExtended(dataToExtended), .dataLen(dataLen),
        .capRdata(capRdata), .capAck(capAck), .capValid(capValid),
        .dataAccept(dataAccept), .dataAbort(dataAbort));

    icr_cap_reg #(.REVISION_CODE(icr_pkg::REV_1P3), .RISING_TRIG(1'b1),
        .SETTLED_IRQ(1'b1), .VENDOR_RESERVED(1'b1))
    icr_cap_reg_legacy_i (.ref_clk(ref_clk), .nrst(nrst),
        .interfaceKind(interfaceKind), .capSel(capSel), .capRead(capRead),
        .capWrite(capWrite), .dataReq(dataReq),
        .dataToExtended(dataToExtended), .dataLen(dataLen),
        .capRdata(capRdata2), .capAck(capAck2), .capValid(capValid2),
        .dataAccept(dataAccept2), .dataAbort(dataAbort2));

    icr_host_model host (.ref_clk(ref_clk), .interfaceKind(interfaceKind),
        .capSel(capSel), .capRead(capRead), .capWrite(capWrite),
        .dataReq(dataReq), .dataToExtended(dataToExtended),
        .dataLen(dataLen), .capRdata(capRdata), .capAck(capAck),
        .dataAccept(dataAccept), .dataAbort(dataAbort));

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic testCapRead();
        logic [31:0] w;
        logic a;
        host.regCycle(1'b0, w, a);
        check(32'(a), 32'h1, "read ack");
        check(32'(capAck2), 32'h1, "legacy ack");
        check(w, WIDE, "wide word");
        check(32'(w[27:11]), 32'h0, "reserved");
        check(32'(w[7:0]), 32'hdd, "irq bits");
        check(capRdata2, LEGACY, "legacy word");
        check(32'(capRdata2[7:0]), 32'h37, "legacy irq");
        $display("capability read test done");
    endtask

    task automatic testWrite();
        logic [31:0] w;
        logic a;
        host.regCycle(1'b1, w, a);
        check(32'(a), 32'h1, "write ack");
        check(w, WIDE, "held on write");
        host.regCycle(1'b0, w, a);
        check(w, WIDE, "word after write");
        $display("write test done");
    endtask

    task automatic testKinds();
        logic [31:0] w;
        logic a;
        logic ok;
        for (int k = 0; k < 16; k++)
        begin
            ok = (k == 0) || (k == 15);
            host.setKind(4'(k));
            host.regCycle(1'b0, w, a);
            check(32'(capValid), 32'(ok), "valid flag");
            check(32'(capValid2), 32'(ok), "legacy valid");
            check(w, ok ? WIDE : 32'h0, "kind word");
        end
        host.setKind(icr_pkg::KIND_FIFO);
        $display("interface kind test done");
    endtask

    task automatic testData();
        logic [7:0] lens [9] = '{8'h01, 8'h04, 8'h05, 8'h20, 8'h21, 8'h00,
            8'h01, 8'h08, 8'h20};
        logic [8:0] ext = 9'h1c0;
        logic [8:0] wAcc = 9'h1cf;
        logic [8:0] lAcc = 9'h003;
        logic acc;
        logic abt;
        logic [31:0] pair;
        for (int i = 0; i < 9; i++)
        begin
            host.dataCycle(ext[i], lens[i][6:0], acc, abt);
            pair = 32'({acc, abt});
            check(pair, 32'({wAcc[i], !wAcc[i]}), "wide");
            pair = 32'({dataAccept2, dataAbort2});
            check(pair, 32'({lAcc[i], !lAcc[i]}), "legacy");
        end
        $display("data gate test done");
    endtask

    // Watchdog: a hang counts as a mismatch and ends the run.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end

    // Reset for 20 cycles, then the scenarios in turn.
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
        testCapRead();
        testWrite();
        testKinds();
        testData();
        finish_test();
    end
endmodule
